/* rtl/tdbg_pkg.sv */
// constants, state type and rule summary for the two-wire debug slave port
// Rules of the port and of the master that drives it
// RQ1: master starts transfers and drives the clock
// RQ2: port works only while instrumentation is off
// RQ3: data changes only while clock is low
// RQ4: start is data falling with clock high
// RQ5: data rising with clock high does nothing
// RQ6: bytes travel most significant bit first
// RQ7: nine clocks per byte, ninth is separator
// RQ8: incoming bits captured on clock rising edge
// RQ9: outgoing bits presented from clock falling edge
// RQ10: master ends by holding clock high
// RQ11: separator high before a fresh start
// RQ12: bus grant waits for high separator
// RQ13: address byte follows every start
// RQ14: seven address bits, then read/write bit
// RQ15: read and write registers share addresses
// RQ16: operation repeats without resending the address
// RQ17: single write takes eight bits after address
// RQ18: write address increments, saturates at 30h
// RQ19: read loads shifter after the address separator
// RQ20: read address increments, saturates at 20h
// RQ21: link clock at most half system clock
// RQ22: recommended link clock per system clock range
// RQ23: bus grant disabled after reset until enabled
// RQ24: lines synchronised, start clears bit counter
// RQ25: data driven only in read data bits
package tdbg_pkg;
    localparam int unsigned SYS_CLK_HZ  = 25_000_000;
    localparam int unsigned LINK_MAX_HZ = SYS_CLK_HZ / 2;
    localparam int          ADDR_W      = 7;
    localparam int          DATA_W      = 8;
    localparam int          CNT_W       = 4;
    localparam int          SYNC_W      = 3;
    localparam int          SYNC_SCL    = 0;
    localparam int          SYNC_SDA    = 1;
    localparam int          SYNC_BREQ   = 2;

    localparam logic [SYNC_W-1:0] SYNC_RESET    = 3'h7;
    localparam logic [CNT_W-1:0]  BIT_FIRST     = 4'h0;
    localparam logic [CNT_W-1:0]  BIT_LAST_DATA = 4'h7;
    localparam logic [CNT_W-1:0]  BIT_SEP       = 4'h8;
    localparam logic [CNT_W-1:0]  BIT_STEP      = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_RESET    = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_STEP     = 7'h01;
    localparam logic [ADDR_W-1:0] WR_ADDR_TOP   = 7'h30;
    localparam logic [ADDR_W-1:0] RD_ADDR_TOP   = 7'h20;
    localparam logic [DATA_W-1:0] DATA_RESET    = 8'h00;
    localparam logic              RW_WRITE      = 1'b0;

    typedef enum logic [1:0] {
        TDBG_IDLE  = 2'b00,
        TDBG_ADDR  = 2'b01,
        TDBG_WRITE = 2'b11,
        TDBG_READ  = 2'b10
    } tdbg_state_t;
endpackage : tdbg_pkg

/* rtl/tdbg_sync.sv */
// two-flop synchroniser for the pins that enter the system clock domain
`timescale 1ns/1ps
module tdbg_sync (
    input  wire logic                        clk,    // system clock
    input  wire logic                        nrst,   // sync reset, low
    input  wire logic [tdbg_pkg::SYNC_W-1:0] async_in, // raw pin levels
    output logic      [tdbg_pkg::SYNC_W-1:0] sync_out  // settled levels
);
    import tdbg_pkg::*;

    logic [SYNC_W-1:0] meta_reg;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_bit
            // the first stage feeds only the second stage
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    meta_reg[gi] <= SYNC_RESET[gi];
                    sync_out[gi] <= SYNC_RESET[gi];
                end else begin
                    meta_reg[gi] <= async_in[gi];
                    sync_out[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate
endmodule : tdbg_sync

/* rtl/tdbg_slave.sv */
// serial slave engine of the two-wire debug port
`timescale 1ns/1ps
module tdbg_slave (
    input  wire logic                        REF_CLK,   // system clock
    input  wire logic                        NRST,      // sync reset, low
    input  wire logic                        INSTR_ENABLE, // pins taken
    input  wire logic                        DEBUG_SERIAL_CLOCK, // link clk
    input  wire logic                        DEBUG_SERIAL_DATA_I, // pin in
    output logic                             DEBUG_SERIAL_DATA_O, // pin out
    output logic                             DEBUG_SERIAL_DATA_OE_N, // drive
    output logic [tdbg_pkg::ADDR_W-1:0]      REG_ADDR,  // register addr
    output logic                             REG_WR,    // write strobe
    output logic [tdbg_pkg::DATA_W-1:0]      REG_WDATA, // write data
    output logic                             REG_RD,    // read strobe
    input  wire logic [tdbg_pkg::DATA_W-1:0] REG_RDATA, // read data
    input  wire logic                        BUS_GRANT_EN_WE, // en write
    input  wire logic                        BUS_GRANT_EN_D,  // en value
    input  wire logic                        BUS_REQUEST_IN_N, // ext req
    output logic                             BUS_GRANT_OUT_N,  // grant
    output logic                             PORT_BUSY  // operation open
);
    import tdbg_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection
    ////////////////////////////////////////////////////////////////////
    logic [SYNC_W-1:0] pins_sync;
    logic              scl_d_reg;
    logic              sda_d_reg;
    logic              scl_s;
    logic              sda_s;
    logic              breq;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_seen;
    logic              sda_rise_hi;

    // the link clock is only sampled, so it must stay below half REF_CLK
    tdbg_sync u_sync (                                        // [RQ24] [RQ21]
        .clk      (REF_CLK),
        .nrst     (NRST),
        .async_in ({BUS_REQUEST_IN_N, DEBUG_SERIAL_DATA_I,
                    DEBUG_SERIAL_CLOCK}),
        .sync_out (pins_sync)
    );

    assign scl_s = pins_sync[SYNC_SCL];
    assign sda_s = pins_sync[SYNC_SDA];
    assign breq  = ~pins_sync[SYNC_BREQ];

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise    = scl_s & ~scl_d_reg;                       // [RQ8]
    assign scl_fall    = ~scl_s & scl_d_reg;                       // [RQ9]
    // a stable-high clock with data falling marks a start
    assign start_seen  = scl_s & scl_d_reg & sda_d_reg & ~sda_s    // [RQ4]
                         & ~INSTR_ENABLE;                          // [RQ2]
    // data rising under a high clock is deliberately left unused
    assign sda_rise_hi = scl_s & scl_d_reg & ~sda_d_reg & sda_s;   // [RQ5]

    ////////////////////////////////////////////////////////////////////
    // framing: state and bit counter
    ////////////////////////////////////////////////////////////////////
    tdbg_state_t       state_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic [DATA_W-1:0] shift_reg;
    logic              sep_rise;
    logic              data_rise;

    assign sep_rise  = scl_rise & (cnt_reg == BIT_SEP);
    assign data_rise = scl_rise & (cnt_reg <= BIT_LAST_DATA);

    always_ff @(posedge REF_CLK) begin
        if (!NRST || INSTR_ENABLE) begin                           // [RQ2]
            state_reg <= TDBG_IDLE;
            cnt_reg   <= BIT_FIRST;
        end else if (start_seen) begin
            state_reg <= TDBG_ADDR;                               // [RQ13]
            cnt_reg   <= BIT_FIRST;                               // [RQ24]
        end else if (state_reg != TDBG_IDLE && scl_rise) begin
            // nine clocks per byte, the ninth is the separator
            if (cnt_reg == BIT_SEP) begin                          // [RQ7]
                cnt_reg <= BIT_FIRST;
            end else begin
                cnt_reg <= CNT_W'(cnt_reg + BIT_STEP);
            end
            // read/write bit picks one of two registers per address
            if (state_reg == TDBG_ADDR && cnt_reg == BIT_SEP) begin
                if (shift_reg[0] == RW_WRITE) begin                // [RQ14]
                    state_reg <= TDBG_WRITE;                      // [RQ15]
                end else begin
                    state_reg <= TDBG_READ;                       // [RQ15]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shifter and data pin
    ////////////////////////////////////////////////////////////////////
    logic              rx_state;
    logic              tx_fall;

    assign rx_state = (state_reg == TDBG_ADDR) || (state_reg == TDBG_WRITE);
    assign tx_fall  = (state_reg == TDBG_READ) && scl_fall
                      && (cnt_reg <= BIT_LAST_DATA);

    always_ff @(posedge REF_CLK) begin
        if (!NRST || start_seen) begin
            shift_reg <= DATA_RESET;
        end else if (rx_state && data_rise) begin
            shift_reg <= {shift_reg[DATA_W-2:0], sda_s};     // [RQ6] [RQ8]
        end else if (tx_fall && cnt_reg == BIT_FIRST) begin
            // read data is loaded on the first fall after the separator
            shift_reg <= {REG_RDATA[DATA_W-2:0], 1'b0};           // [RQ19]
        end else if (tx_fall) begin
            shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};            // [RQ6]
        end
    end

    // pin changes only follow a detected falling edge, so clock is low
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            DEBUG_SERIAL_DATA_O <= 1'b1;
        end else if (tx_fall && cnt_reg == BIT_FIRST) begin
            DEBUG_SERIAL_DATA_O <= REG_RDATA[DATA_W-1];      // [RQ9] [RQ3]
        end else if (tx_fall) begin
            DEBUG_SERIAL_DATA_O <= shift_reg[DATA_W-1];           // [RQ9]
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST || INSTR_ENABLE || start_seen) begin
            DEBUG_SERIAL_DATA_OE_N <= 1'b1;
        end else if (state_reg != TDBG_READ) begin
            DEBUG_SERIAL_DATA_OE_N <= 1'b1;                       // [RQ25]
        end else if (scl_fall) begin
            // released for the separator cycle
            DEBUG_SERIAL_DATA_OE_N <= (cnt_reg == BIT_SEP);       // [RQ25]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register space access
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            REG_ADDR <= ADDR_RESET;
        end else if (sep_rise && state_reg == TDBG_ADDR) begin
            REG_ADDR <= shift_reg[DATA_W-1:1];                   // [RQ14]
        end else if (sep_rise && state_reg == TDBG_WRITE) begin
            // block writes walk upward and stick at the top
            if (REG_ADDR < WR_ADDR_TOP) begin                     // [RQ18]
                REG_ADDR <= ADDR_W'(REG_ADDR + ADDR_STEP);
            end
        end else if (sep_rise && state_reg == TDBG_READ) begin
            if (REG_ADDR < RD_ADDR_TOP) begin                     // [RQ20]
                REG_ADDR <= ADDR_W'(REG_ADDR + ADDR_STEP);
            end
        end
    end

    // staying in WRITE/READ lets the master repeat without an address
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            REG_WR    <= 1'b0;
            REG_WDATA <= DATA_RESET;
        end else begin
            REG_WR <= (state_reg == TDBG_WRITE) && scl_rise       // [RQ17]
                      && (cnt_reg == BIT_LAST_DATA);              // [RQ16]
            if (state_reg == TDBG_WRITE && scl_rise
                && cnt_reg == BIT_LAST_DATA) begin
                REG_WDATA <= {shift_reg[DATA_W-2:0], sda_s};      // [RQ17]
            end
        end
    end

    // read strobe at each read separator so data is ready at the next fall
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            REG_RD <= 1'b0;
        end else begin
            REG_RD <= sep_rise && (((state_reg == TDBG_ADDR)      // [RQ19]
                      && (shift_reg[0] != RW_WRITE))
                      || (state_reg == TDBG_READ));               // [RQ16]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus request hand-off
    ////////////////////////////////////////////////////////////////////
    logic grant_en_reg;
    logic sep_high_reg;
    logic busy;

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            grant_en_reg <= 1'b0;                                 // [RQ23]
        end else if (BUS_GRANT_EN_WE) begin
            grant_en_reg <= BUS_GRANT_EN_D;
        end
    end

    // a high separator ends the operation; the next byte reopens it
    always_ff @(posedge REF_CLK) begin
        if (!NRST || INSTR_ENABLE) begin
            sep_high_reg <= 1'b1;
        end else if (start_seen) begin
            sep_high_reg <= 1'b0;
        end else if (state_reg != TDBG_IDLE && sep_rise) begin
            sep_high_reg <= sda_s;                                // [RQ12]
        end else if (state_reg != TDBG_IDLE && scl_rise
                     && cnt_reg == BIT_FIRST) begin
            sep_high_reg <= 1'b0;
        end
    end

    assign busy = (state_reg != TDBG_IDLE) && !sep_high_reg;

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            BUS_GRANT_OUT_N <= 1'b1;
            PORT_BUSY       <= 1'b0;
        end else begin
            BUS_GRANT_OUT_N <= ~(grant_en_reg && breq && !busy);  // [RQ12]
            PORT_BUSY       <= busy;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions and cover points
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);

    AST_DRIVE_ONLY_READ: assert property (                        // [RQ25]
        !DEBUG_SERIAL_DATA_OE_N |-> state_reg == TDBG_READ
        && cnt_reg <= BIT_SEP && $past(state_reg) == TDBG_READ)
        else $error("data pin driven outside read data bits");

    AST_INSTR_IDLE: assert property (                              // [RQ2]
        INSTR_ENABLE |=> state_reg == TDBG_IDLE
        && DEBUG_SERIAL_DATA_OE_N)
        else $error("port active while instrumentation on");

    AST_START_CLEARS: assert property (                           // [RQ24]
        start_seen |=> state_reg == TDBG_ADDR && cnt_reg == BIT_FIRST
        && busy ##1 PORT_BUSY)
        else $error("start did not restart the framing");

    AST_IDLE_IGNORES: assert property (                            // [RQ4]
        state_reg == TDBG_IDLE |=> !REG_WR && !REG_RD)
        else $error("register access without a start");

    AST_DATA_RISE_NOP: assert property (                           // [RQ5]
        sda_rise_hi && !INSTR_ENABLE |=> $stable(state_reg)
        && $stable(cnt_reg))
        else $error("data rise under high clock changed state");

    AST_PIN_ON_FALL: assert property (                        // [RQ9] [RQ3]
        !DEBUG_SERIAL_DATA_OE_N && $changed(DEBUG_SERIAL_DATA_O)
        |-> $past(scl_fall) && !$past(scl_s))
        else $error("data pin moved outside a clock low phase");

    AST_WRITE_BYTE: assert property (                        // [RQ17] [RQ8]
        REG_WR |-> $past(state_reg) == TDBG_WRITE
        && $past(cnt_reg) == BIT_LAST_DATA && $past(scl_rise)
        && REG_WDATA == $past({shift_reg[DATA_W-2:0], sda_s}))
        else $error("write strobe not on the eighth data rise");

    AST_WR_SATURATE: assert property (                            // [RQ18]
        state_reg == TDBG_WRITE && sep_rise && REG_ADDR == WR_ADDR_TOP
        |=> REG_ADDR == WR_ADDR_TOP)
        else $error("write address moved past its top");

    AST_WR_INCREMENT: assert property (                           // [RQ18]
        state_reg == TDBG_WRITE && sep_rise && REG_ADDR < WR_ADDR_TOP
        |=> REG_ADDR == $past(REG_ADDR) + ADDR_STEP)
        else $error("write address did not step by one");

    AST_RD_SATURATE: assert property (                            // [RQ20]
        state_reg == TDBG_READ && sep_rise && REG_ADDR == RD_ADDR_TOP
        |=> REG_ADDR == RD_ADDR_TOP && REG_RD)
        else $error("read address moved past its top");

    AST_ADDR_DECODE: assert property (                       // [RQ14] [RQ19]
        state_reg == TDBG_ADDR && sep_rise && !start_seen
        && shift_reg[0] != RW_WRITE
        |=> state_reg == TDBG_READ && REG_RD
        && REG_ADDR == $past(shift_reg[DATA_W-1:1]))
        else $error("read command not decoded");

    AST_NINE_CLOCKS: assert property (                             // [RQ7]
        cnt_reg <= BIT_SEP)
        else $error("bit counter beyond the separator");

    AST_GRANT_GATED: assert property (                      // [RQ23] [RQ12]
        !BUS_GRANT_OUT_N |-> $past(grant_en_reg) && !$past(busy))
        else $error("bus granted while disabled or busy");

    COV_WRITE: cover property (REG_WR ##[1:200] REG_WR);
    COV_READ_BLOCK: cover property (REG_RD ##[1:200] REG_RD);
    COV_GRANT: cover property ($fell(BUS_GRANT_OUT_N));
    COV_READ_DRIVE: cover property ($fell(DEBUG_SERIAL_DATA_OE_N));
endmodule : tdbg_slave

/* tb/tdbg_probe.sv */
// serial master model that clocks the debug port from the probe side
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module tdbg_probe (
    input  wire logic clk,       // system clock, paces the link phases
    input  wire logic sda_line,  // resolved data line level
    output logic      scl,       // link clock, parks high
    output logic      sda_drv,   // data value while driving
    output logic      sda_oe_n   // low while the probe drives data
);
    logic glitch;  // raise data inside the next low separator's high phase
    initial begin
        scl      = 1'b1;  // link clock stands still outside frames
        sda_drv  = 1'b1;
        sda_oe_n = 1'b1;  // released: the pull-up holds the line high
        glitch   = 1'b0;
    end
    // 4 system clocks per half period: 3.125 MHz, a safe margin
    task automatic q(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : q
    // every transfer starts here, on the probe's own initiative
    task automatic start();
        if (!(scl && sda_line)) begin
            scl = 1'b0;
            q(2);
            sda_oe_n = 1'b0;
            sda_drv = 1'b1;
            q(2);
            scl = 1'b1;
            q(4);
        end
        sda_oe_n = 1'b0;
        sda_drv = 1'b0;  // the only falling data edge made with the clock high
        q(4);
    endtask : start
    // nb < 8 leaves a partial byte with no separator, to be aborted
    task automatic xfer(input logic [7:0] wb, input logic rd,
                        input logic sep, input int nb, output logic [7:0] rb);
        rb = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            scl = 1'b0;
            q(2);
            sda_oe_n = rd;  // released while the device answers
            sda_drv = wb[i];  // most significant bit first
            q(2);
            scl = 1'b1;  // data moved only while the clock was low
            q(4);
            rb[i] = sda_line;  // late in the high phase, safe from the fall
        end
        if (nb < 8)
            return;
        scl = 1'b0;
        q(2);
        sda_oe_n = 1'b0;
        sda_drv = sep;  // high only where the operation ends
        q(2);
        scl = 1'b1;  // ninth clock of the unit carries the separator
        q(2);
        if (glitch && !sep) begin
            sda_drv = 1'b1;
            glitch = 1'b0;
        end
        q(2);
        // clock left parked high; the next unit lowers it first
    endtask : xfer
endmodule : tdbg_probe

/* tb/testbench.sv */
// self-checking bench for the two-wire debug slave port
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
    $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
    fails++; end end
////////////////////////////////////////////////////////////////////////////
module testbench;
    import tdbg_pkg::*;
    logic              ref_clk, nrst, instr_en, ge_we, ge_d, breq_n;
    logic              scl, m_sda, m_oe_n, d_sda, d_oe_n, drove;
    logic              reg_wr, reg_rd, grant_n, busy;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [DATA_W-1:0] rd_mem [0:127];
    logic [14:0]       wq [$];
    wire               sda_wire;
    int                fails, tests_run;
    // the device wins any overlap; a released line floats to the pull-up
    assign sda_wire = !d_oe_n ? d_sda : (!m_oe_n ? m_sda : 1'b1);
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (reg_wr)
            wq.push_back({reg_addr, reg_wdata});
        if (reg_rd)
            reg_rdata <= rd_mem[reg_addr];
        if (!d_oe_n)
            drove = 1'b1;
    end
    tdbg_probe probe_u (.clk(ref_clk), .sda_line(sda_wire), .scl(scl),
                        .sda_drv(m_sda), .sda_oe_n(m_oe_n));
    tdbg_slave dut_u (.REF_CLK(ref_clk), .NRST(nrst), .INSTR_ENABLE(instr_en),
        .DEBUG_SERIAL_CLOCK(scl), .DEBUG_SERIAL_DATA_I(sda_wire),
        .DEBUG_SERIAL_DATA_O(d_sda), .DEBUG_SERIAL_DATA_OE_N(d_oe_n),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .BUS_GRANT_EN_WE(ge_we),
        .BUS_GRANT_EN_D(ge_d), .BUS_REQUEST_IN_N(breq_n),
        .BUS_GRANT_OUT_N(grant_n), .PORT_BUSY(busy));
////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rdv(input int a);
        return 8'(a) ^ 8'hc3;
    endfunction : rdv
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic addr_phase(input logic [6:0] a, input logic rw);
        logic [7:0] x;
        probe_u.start();
        probe_u.xfer({a, rw}, 1'b0, 1'b0, 8, x);  // address first
    endtask : addr_phase
    task automatic wcmd(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        addr_phase(a, RW_WRITE);
        probe_u.xfer(d, 1'b0, 1'b1, 8, x);
        cyc(6);
    endtask : wcmd
    task automatic chk_wr(input logic [6:0] a, input logic [7:0] d);
        logic [14:0] v;
        v = (wq.size() > 0) ? wq.pop_front() : 'x;
        `CHK("write addr+data", {a, d}, v)
    endtask : chk_wr
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK("oe_n", 1'b1, d_oe_n)
        `CHK("busy", 1'b0, busy)
        breq_n = 1'b0;
        cyc(10);
        `CHK("grant", 1'b1, grant_n)
        breq_n = 1'b1;
        $display("test reset done");
    endtask : t_reset
    task automatic t_ignore();
        logic [7:0] x;
        probe_u.xfer({7'h05, RW_WRITE}, 1'b0, 1'b0, 8, x);
        probe_u.xfer(8'h11, 1'b0, 1'b1, 8, x);
        cyc(6);
        `CHK("writes", 0, wq.size())
        instr_en = 1'b1;
        drove = 1'b0;
        wcmd(7'h05, 8'h11);
        addr_phase(7'h00, 1'b1);
        probe_u.xfer(8'hff, 1'b1, 1'b1, 8, x);
        `CHK("writes", 0, wq.size())
        `CHK("drove", 1'b0, drove)
        instr_en = 1'b0;
        $display("test ignore done");
    endtask : t_ignore
    task automatic t_write();
        drove = 1'b0;
        wcmd(7'h00, 8'hb4);
        wcmd(7'h4b, 8'h69);
        chk_wr(7'h00, 8'hb4);
        chk_wr(7'h4b, 8'h69);
        `CHK("drove", 1'b0, drove)
        $display("test write done");
    endtask : t_write
    task automatic t_abort();
        logic [7:0] x;
        probe_u.start();
        probe_u.xfer(8'hf0, 1'b0, 1'b0, 4, x);
        wcmd(7'h12, 8'h3c);
        chk_wr(7'h12, 8'h3c);
        `CHK("writes", 0, wq.size())
        $display("test abort done");
    endtask : t_abort
    task automatic t_bwrite();
        logic [7:0] x;
        ge_d = 1'b1;
        ge_we = 1'b1;
        cyc(1);
        ge_we = 1'b0;
        breq_n = 1'b0;
        cyc(6);
        `CHK("grant idle", 1'b0, grant_n)
        addr_phase(7'h2e, RW_WRITE);
        `CHK("grant busy", 1'b1, grant_n)
        `CHK("busy open", 1'b1, busy)
        for (int k = 0; k < 4; k++) begin
            probe_u.glitch = (k == 1);
            probe_u.xfer(8'h61 + 8'(k), 1'b0, k == 3, 8, x);
            if (k < 3) `CHK("grant sep low", 1'b1, grant_n)
        end
        cyc(8);
        `CHK("grant done", 1'b0, grant_n)
        `CHK("busy closed", 1'b0, busy)
        breq_n = 1'b1;
        for (int k = 0; k < 4; k++)
            chk_wr(k < 2 ? 7'h2e + 7'(k) : WR_ADDR_TOP,
                   8'h61 + 8'(k));
        $display("test block write done");
    endtask : t_bwrite
    task automatic t_read();
        logic [7:0] r;
        int         ea;
        drove = 1'b0;
        addr_phase(7'h00, 1'b1);
        probe_u.xfer(8'hff, 1'b1, 1'b1, 8, r);
        `CHK("read 00", rdv(0), r)
        `CHK("released", 1'b1, d_oe_n)
        `CHK("drove", 1'b1, drove)
        addr_phase(7'h1e, 1'b1);
        for (int k = 0; k < 4; k++) begin
            ea = (k < 2) ? 'h1e + k : int'(RD_ADDR_TOP);
            probe_u.xfer(8'hff, 1'b1, k == 3, 8, r);
            `CHK("block read", rdv(ea), r)
        end
        $display("test read done");
    endtask : t_read
////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        instr_en = 1'b0;
        ge_we = 1'b0;
        ge_d = 1'b0;
        breq_n = 1'b1;
        reg_rdata = 8'h00;
        drove = 1'b0;
        fails = 0;
        tests_run = 0;
        for (int i = 0; i < 128; i++)
            rd_mem[i] = rdv(i);
        cyc(20);
        nrst = 1'b1;
        cyc(4);
        t_reset();
        t_ignore();
        t_write();
        t_abort();
        t_bwrite();
        t_read();
        finish_test();
    end
    // about 1900 cycles are needed; the limit leaves ample margin
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("MISMATCH watchdog expected finish seen timeout");
        finish_test();
    end
endmodule : testbench
